/* hw/gpb_pkg.sv */
// package for the gpio port register bank: offsets, reset values, pad and register carriers
// assumes a byte-wide register port and eight pads per port
package gpb_pkg;

  localparam int GPB_WIDTH = 8;
  localparam int GPB_ADDR_W = 3;

  // register offsets
  localparam logic [2:0] GPB_OFS_OUTPUT_LATCH = 3'h0;
  localparam logic [2:0] GPB_OFS_PIN_LEVELS = 3'h1;
  localparam logic [2:0] GPB_OFS_DIRECTION = 3'h2;
  localparam logic [2:0] GPB_OFS_PULL_DRIVE = 3'h3;
  localparam logic [2:0] GPB_OFS_IRQ_SPEED = 3'h4;

  // reset values
  localparam logic [7:0] GPB_RST_OUTPUT_LATCH = 8'h00;
  localparam logic [7:0] GPB_RST_DIRECTION = 8'h00;
  localparam logic [7:0] GPB_RST_PULL_DRIVE = 8'h00;
  localparam logic [7:0] GPB_RST_FIRST_PORT_PULL_DRIVE = 8'h01;
  localparam logic [7:0] GPB_RST_IRQ_SPEED = 8'h00;
  localparam logic [7:0] GPB_UNMAPPED_READ = 8'h00;
  localparam logic [7:0] GPB_ALL_CLEAR = 8'h00;

  // output speed settings in MHz
  localparam int GPB_SLOW_SPEED_MHZ = 2;
  localparam int GPB_FAST_SPEED_MHZ = 10;

  // per-pin pad control, one bit per pin in each field
  typedef struct packed {
    logic [7:0] out_level;   // level driven when the pad drives
    logic [7:0] out_en_n;    // low while the port drives the pad
    logic [7:0] pull_up_en;  // weak pull-up on
    logic [7:0] fast_slew;   // high-speed slew on
  } gpb_pad_ctrl_t;

  // software-visible configuration
  typedef struct packed {
    logic [7:0] output_latch;
    logic [7:0] direction;
    logic [7:0] pull_drive_select;
    logic [7:0] irq_speed_select;
  } gpb_regs_t;

endpackage : gpb_pkg

/* hw/gpb_port.sv */
// one 8-bit gpio port: five byte registers, pad control and interrupt request lines
// assumes pads and pad straps come from outside the clock domain; straps are static
`timescale 1ns/1ps

module gpb_port import gpb_pkg::*; #(
  parameter bit FIRST_PORT = 1'b0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // pad straps: which pads are fast-capable, true open-drain, interrupt-capable
  input wire logic [7:0] pad_fast_capable,
  input wire logic [7:0] pad_true_open_drain,
  input wire logic [7:0] pad_irq_capable,
  // pads
  input wire logic [7:0] pad_in,
  output gpb_pad_ctrl_t pad_ctrl,
  // external interrupt controller
  output logic [7:0] irq_request
);

  gpb_regs_t regs;
  logic [7:0] pin_sync1;
  logic [7:0] pin_levels;
  logic [7:0] fast_sync1;
  logic [7:0] fast_cap;
  logic [7:0] tod_sync1;
  logic [7:0] tod;
  logic [7:0] irqcap_sync1;
  logic [7:0] irq_cap;
  logic [7:0] next_rdata;
  gpb_pad_ctrl_t next_pad_ctrl;
  logic [7:0] next_irq_request;

  function automatic logic reg_hit(input logic [2:0] addr, input logic [2:0] ofs);
    reg_hit = (addr == ofs);
  endfunction : reg_hit

  // pin levels pass two flops before anything reads them; no reset so they follow the pins
  always_ff @(posedge core_clk) begin
    pin_sync1 <= pad_in;
    pin_levels <= pin_sync1;
  end

  // straps are synchronized the same way; they are meant to be static
  always_ff @(posedge core_clk) begin
    fast_sync1 <= pad_fast_capable;
    fast_cap <= fast_sync1;
    tod_sync1 <= pad_true_open_drain;
    tod <= tod_sync1;
    irqcap_sync1 <= pad_irq_capable;
    irq_cap <= irqcap_sync1;
  end

  // whole-byte writes; single-bit set/clear is software reading then writing the byte
  always_ff @(posedge core_clk) begin
    if (srst) begin
      regs.output_latch <= GPB_RST_OUTPUT_LATCH;
    end else if (reg_write && reg_hit(reg_addr, GPB_OFS_OUTPUT_LATCH)) begin
      regs.output_latch <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      regs.direction <= GPB_RST_DIRECTION;
    end else if (reg_write && reg_hit(reg_addr, GPB_OFS_DIRECTION)) begin
      regs.direction <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      regs.pull_drive_select <= FIRST_PORT ? GPB_RST_FIRST_PORT_PULL_DRIVE : GPB_RST_PULL_DRIVE;
    end else if (reg_write && reg_hit(reg_addr, GPB_OFS_PULL_DRIVE)) begin
      regs.pull_drive_select <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      regs.irq_speed_select <= GPB_RST_IRQ_SPEED;
    end else if (reg_write && reg_hit(reg_addr, GPB_OFS_IRQ_SPEED)) begin
      regs.irq_speed_select <= reg_wdata;
    end
  end

  // read mux; the pin level register ignores writes since no write path exists
  always_comb begin
    next_rdata = GPB_UNMAPPED_READ;
    unique case (reg_addr)
      GPB_OFS_OUTPUT_LATCH: next_rdata = regs.output_latch;
      GPB_OFS_PIN_LEVELS: next_rdata = pin_levels;
      GPB_OFS_DIRECTION: next_rdata = regs.direction;
      GPB_OFS_PULL_DRIVE: next_rdata = regs.pull_drive_select;
      GPB_OFS_IRQ_SPEED: next_rdata = regs.irq_speed_select;
      default: next_rdata = GPB_UNMAPPED_READ;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= GPB_ALL_CLEAR;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= GPB_ALL_CLEAR;
    end
  end

  // pad control, computed bitwise so bit n only touches pin n
  always_comb begin
    next_pad_ctrl = '0;
    for (int n = 0; n < GPB_WIDTH; n++) begin
      next_pad_ctrl.out_level[n] = regs.output_latch[n];
      if (regs.direction[n]) begin
        // push-pull drives both levels; open-drain only pulls low
        if (regs.pull_drive_select[n] && !tod[n]) begin
          next_pad_ctrl.out_en_n[n] = 1'b0;
        end else begin
          next_pad_ctrl.out_en_n[n] = regs.output_latch[n];
        end
        next_pad_ctrl.pull_up_en[n] = 1'b0;
        next_pad_ctrl.fast_slew[n] = regs.irq_speed_select[n] && fast_cap[n];
      end else begin
        next_pad_ctrl.out_en_n[n] = 1'b1;
        next_pad_ctrl.pull_up_en[n] = regs.pull_drive_select[n] && !tod[n];
        next_pad_ctrl.fast_slew[n] = 1'b0;
      end
    end
  end

  // interrupt requests only from input pins with the enable set
  always_comb begin
    next_irq_request = ~regs.direction & regs.irq_speed_select & irq_cap & pin_levels;
  end

  // registered outputs; pads released during reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pad_ctrl.out_level <= GPB_ALL_CLEAR;
      pad_ctrl.out_en_n <= ~GPB_ALL_CLEAR;
      pad_ctrl.pull_up_en <= GPB_ALL_CLEAR;
      pad_ctrl.fast_slew <= GPB_ALL_CLEAR;
      irq_request <= GPB_ALL_CLEAR;
    end else begin
      pad_ctrl <= next_pad_ctrl;
      irq_request <= next_irq_request;
    end
  end

endmodule : gpb_port

/* test/gpb_port_props.sv */
// checker for gpb_port: pad control and request lines against their causes
// assumes static straps and srst held two edges
`timescale 1ns/1ps
module gpb_port_props import gpb_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // pads
  input wire logic [7:0] pad_fast_capable,
  input wire logic [7:0] pad_true_open_drain,
  input wire logic [7:0] pad_irq_capable,
  input wire logic [7:0] pad_in,
  input wire gpb_pad_ctrl_t pad_ctrl,
  input wire logic [7:0] irq_request
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  property p_rd_idle; !$past(reg_read) |-> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_unmapped; reg_read && reg_addr > 3'h4 |=> reg_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rst_out; $fell(srst) |-> pad_ctrl.out_en_n == 8'hff && pad_ctrl.fast_slew == 8'h00; endproperty
  a_rst_out: assert property (p_rst_out) else $error("pads not floating after reset");
  property p_irq_dir; (irq_request & ~pad_ctrl.out_en_n) == 8'h00; endproperty
  a_irq_dir: assert property (p_irq_dir) else $error("request on driven pin");
  property p_irq_cap; (irq_request & ~pad_irq_capable) == 8'h00; endproperty
  a_irq_cap: assert property (p_irq_cap) else $error("request on incapable pin");
  property p_irq_pin; (irq_request & ~$past(pad_in, 3)) == 8'h00; endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("request without pin high");
  property p_fast_cap; (pad_ctrl.fast_slew & ~pad_fast_capable) == 8'h00; endproperty
  a_fast_cap: assert property (p_fast_cap) else $error("fast slew on slow pad");
  property p_od_pull; (pad_ctrl.pull_up_en & (pad_true_open_drain | ~pad_ctrl.out_en_n)) == 8'h00; endproperty
  a_od_pull: assert property (p_od_pull) else $error("pull-up where not allowed");
  c_irq: cover property (irq_request != 8'h00);
  c_fast: cover property (pad_ctrl.fast_slew != 8'h00);
  c_unmapped: cover property (reg_read && reg_addr > 3'h4);
endmodule : gpb_port_props

/* test/gpb_pad_model.sv */
// pad model: resolves each pad from port drive, pull-up and board level
// assumes board resistors are weaker than the internal pull-up
`timescale 1ns/1ps
module gpb_pad_model import gpb_pkg::*; (
  // port side
  input wire gpb_pad_ctrl_t pad_ctrl,
  // board side
  input wire logic [7:0] ext_level,
  output logic [7:0] pad_in
);
  assign pad_in = (pad_ctrl.out_level & ~pad_ctrl.out_en_n) | ((ext_level | pad_ctrl.pull_up_en) & pad_ctrl.out_en_n);
endmodule : gpb_pad_model

/* test/gpb_port_test.sv */
// bench for gpb_port: register sequences with pad and request checks
// assumes fixed straps: fast 0f, true open-drain 80, irq f0
`timescale 1ns/1ps
module gpb_port_test;
  import gpb_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] ext_level = 8'h3c;
  logic [7:0] reg_rdata, pad_in, irq_request;
  gpb_pad_ctrl_t pad_ctrl;
  int errors = 0, n_tests = 0;
  gpb_port #(.FIRST_PORT(1'b1)) u_gpb_port (.core_clk, .srst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .pad_fast_capable(8'h0f), .pad_true_open_drain(8'h80), .pad_irq_capable(8'hf0), .pad_in,
    .pad_ctrl, .irq_request);
  gpb_pad_model u_gpb_pad_model (.pad_ctrl, .ext_level, .pad_in);
  initial forever #2.5 core_clk = ~core_clk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // writes wait four edges so pads and requests settle
  task automatic bus(input bit rd, input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= !rd;
    reg_read <= rd;
    @(posedge core_clk);
    reg_write <= 1'b0;
    reg_read <= 1'b0;
    if (!rd) repeat (4) @(posedge core_clk);
    #1;
    if (rd) chk(reg_rdata, d);
  endtask : bus
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    bus(1, 3'h0, 8'h00);
    bus(1, 3'h2, 8'h00);
    bus(1, 3'h3, 8'h01);
    bus(1, 3'h4, 8'h00);
    chk(pad_ctrl.pull_up_en, 8'h01);
    bus(0, 3'h1, 8'hff);
    bus(1, 3'h1, 8'h3d);
    for (int a = 5; a < 8; a++) bus(1, 3'(a), 8'h00);
    bus(0, 3'h0, 8'ha5);
    chk(pad_ctrl.out_en_n, 8'hff);
    bus(1, 3'h0, 8'ha5);
    bus(0, 3'h0, 8'ha7);
    bus(1, 3'h0, 8'ha7);
    bus(0, 3'h2, 8'hff);
    bus(0, 3'h3, 8'hff);
    chk(pad_ctrl.out_en_n, 8'h80);
    chk(pad_ctrl.out_level, 8'ha7);
    bus(1, 3'h1, 8'h27);
    bus(0, 3'h3, 8'h00);
    chk(pad_ctrl.out_en_n, 8'ha7);
    bus(1, 3'h1, 8'h24);
    bus(0, 3'h4, 8'hff);
    chk(pad_ctrl.fast_slew, 8'h0f);
    bus(0, 3'h2, 8'h00);
    chk(pad_ctrl.fast_slew, 8'h00);
    chk(irq_request, 8'h30);
    @(posedge core_clk);
    ext_level <= 8'hc3;
    bus(0, 3'h3, 8'h81);
    chk(pad_ctrl.pull_up_en, 8'h01);
    chk(irq_request, 8'hc0);
    bus(0, 3'h4, 8'h40);
    chk(irq_request, 8'h40);
    bus(1, 3'h1, 8'hc3);
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    bus(1, 3'h0, 8'h00);
    chk(irq_request, 8'h00);
    close_out;
  end
endmodule : gpb_port_test
bind gpb_port gpb_port_props u_gpb_port_props (.core_clk, .srst, .reg_addr, .reg_read, .reg_rdata,
  .pad_fast_capable, .pad_true_open_drain, .pad_irq_capable, .pad_in, .pad_ctrl, .irq_request);
